// ---- rtl/adc_host_cfg.svh ----
`ifndef ADC_HOST_CFG_SVH
`define ADC_HOST_CFG_SVH

// ==========================================================================
// Timing
`define CLK_HZ 40000000
`define BYTE_RATE_MIN 9600
`define BYTE_RATE_MAX 115200
// Half a serial clock period in host cycles; eight bits make one byte.
`define HALF_MIN ((`CLK_HZ + 16 * `BYTE_RATE_MAX - 1) / (16 * `BYTE_RATE_MAX))
`define HALF_MAX (`CLK_HZ / (16 * `BYTE_RATE_MIN))
`define CS_GAP_CYCLES 4
`define CONV_TIMEOUT_US 100
`define CONV_TIMEOUT_CYCLES (`CONV_TIMEOUT_US * (`CLK_HZ / 1000000))

// ==========================================================================
// Register offsets
`define REG_CTRL 4'h0
`define REG_INSTR 4'h1
`define REG_WDATA 4'h2
`define REG_DIRECT 4'h3
`define REG_RATE 4'h4
`define REG_STATUS 4'h5
`define REG_RDATA 4'h6

// ==========================================================================
// Field positions
`define CTRL_GO_REG 0
`define CTRL_GO_DIRECT 1
`define CTRL_BYTE_ORDER 2
`define CTRL_WRITE 3
`define CTRL_WIDE 4
`define STAT_ACTIVE 0
`define STAT_DONE 1
`define STAT_ERROR 2
`define STAT_CFG_DONE 3
`define STAT_BUSY 4
`define STAT_RATE_SET 5

// ==========================================================================
// Commands
`define INSTR_REFOSC 8'h07
`define DATA_REFOSC 8'h3B
`define INSTR_RESET 8'h00
`define DATA_RESET 8'h00

`endif

// ---- rtl/adc_host_pkg.sv ----
package adc_host_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_GAP = 2'b10,
        ST_CONV = 2'b11
    } phase_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic sdi;
    } link_out_t;

    typedef struct packed {
        phase_t phase;
        link_out_t link;
        logic [23:0] tx;
        logic [15:0] rx;
        logic [4:0] bits;
        logic is_read;
        logic is_direct;
        logic refosc_frame;
        logic reset_frame;
        logic [7:0] instr;
        logic [15:0] wdata;
        logic [6:0] direct;
        logic [15:0] half;
        logic byte_order;
        logic wr_mode;
        logic wide;
        logic rate_set;
        logic cfg_done;
        logic done;
        logic error;
        logic busy_seen;
        logic [11:0] timer;
        logic [15:0] result;
        logic [15:0] rdata;
    } host_state_t;

    typedef struct packed {
        logic [2:0] pipe;
        logic level;
    } sync_state_t;

    typedef struct packed {
        logic [15:0] count;
        logic tick;
    } div_state_t;

endpackage : adc_host_pkg

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module pin_sync
    import adc_host_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Pin and filtered level
    input wire logic i_pin,
    output logic o_level
);

    sync_state_t st_reg;
    sync_state_t st_next;

    // The level only moves once the second and third stages agree.
    always_comb begin
        st_next = st_reg;
        st_next.pipe = {st_reg.pipe[1:0], i_pin};
        if (st_reg.pipe[1] == st_reg.pipe[2]) begin
            st_next.level = st_reg.pipe[2];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_level = st_reg.level;

endmodule : pin_sync

`default_nettype wire

// ---- rtl/half_divider.sv ----
`timescale 1ns/1ps
`default_nettype none

module half_divider
    import adc_host_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Control
    input wire logic i_run,
    input wire logic [15:0] i_half,
    // One-cycle pulse at the end of each half period
    output logic o_tick
);

    div_state_t st_reg;
    div_state_t st_next;

    // Held at zero while stopped so the first half period is always whole.
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (!i_run) begin
            st_next.count = 16'h0000;
        end else if (st_reg.count >= i_half - 16'h0001) begin
            st_next.count = 16'h0000;
            st_next.tick = 1'b1;
        end else begin
            st_next.count = st_reg.count + 16'h0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_tick = st_reg.tick;

endmodule : half_divider

`default_nettype wire

// ---- rtl/adc_host_ctrl.sv ----
// Overview of operation
// R1: A direct conversion byte carries a one in bit 7, gain in bits 6-4, channel in bits 3-0.
// R2: The converter starts converting as soon as the last bit of a direct byte is in.
// R3: A direct byte with bit 7 clear is an error, so the host never sends one.
// R4: Gain codes 0 to 7 select gains of 1, 2, 4, 5, 8, 10, 16 and 20.
// R5: The converter holds its busy line high during a conversion and low otherwise.
// R6: The serial port is live only while the active-low select is low; idle is high.
// R7: The converter samples on the rising serial clock edge, so data changes on the fall.
// R8: The conversion clock pin is an input, held low as an external conversion clock.
// R9: Host data goes out on its own line and converter data returns on a separate line.
// R10: Register access sends an instruction byte, then 8 or 16 data bits in or out.
// R11: Direct conversions need MSB-first byte order and the oscillator enabled first.
// R12: Instruction 0x07 with data 0x3B programs and enables the reference and oscillator.
// R13: Instruction 0x00 with data 0x00 resets the converter.
// R14: The host clocks 9600 to 115200 bytes per second and sets the rate before first use.
// R15: The hardware trigger is pulled low, so only serial commands start conversions.
// R16: Channel codes 0-7 pick differential pairs and 8-15 single-ended inputs.
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_host_cfg.svh"

module adc_host_ctrl
    import adc_host_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Software register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [15:0] o_rdata,
    // Converter serial link
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi,
    input wire logic i_sdo,
    input wire logic i_busy
);

    localparam logic [15:0] HALF_LO = 16'(`HALF_MIN);
    localparam logic [15:0] HALF_HI = 16'(`HALF_MAX);
    localparam logic [11:0] GAP_LAST = 12'(`CS_GAP_CYCLES - 1);
    localparam logic [11:0] CONV_LAST = 12'(`CONV_TIMEOUT_CYCLES - 1);

    host_state_t st_reg;
    host_state_t st_next;
    logic sdo_level;
    logic busy_level;
    logic tick;
    logic wr_hit;
    logic [15:0] rate_in;

    // ======================================================================
    // Pin inputs and serial clock divider

    pin_sync u_sdo_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin(i_sdo),
        .o_level(sdo_level)
    );

    pin_sync u_busy_sync (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_pin(i_busy),
        .o_level(busy_level)
    );

    half_divider u_div (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_run(st_reg.phase == ST_SHIFT),
        .i_half(st_reg.half),
        .o_tick(tick)
    );

    // ======================================================================
    // Register port and frame sequencer

    always_comb begin
        st_next = st_reg;
        st_next.rdata = 16'h0000;
        wr_hit = i_write && (st_reg.phase == ST_IDLE);
        rate_in = i_wdata;
        // Out-of-range rates are pinned to the nearest legal one.
        if (i_wdata < HALF_LO) begin
            rate_in = HALF_LO; // R14
        end else if (i_wdata > HALF_HI) begin
            rate_in = HALF_HI; // R14
        end

        if (i_read) begin
            case (i_addr)
                `REG_CTRL: begin
                    st_next.rdata[`CTRL_BYTE_ORDER] = st_reg.byte_order;
                    st_next.rdata[`CTRL_WRITE] = st_reg.wr_mode;
                    st_next.rdata[`CTRL_WIDE] = st_reg.wide;
                end
                `REG_INSTR: st_next.rdata = {8'h00, st_reg.instr};
                `REG_WDATA: st_next.rdata = st_reg.wdata;
                `REG_DIRECT: st_next.rdata = {9'h000, st_reg.direct};
                `REG_RATE: st_next.rdata = st_reg.half;
                `REG_STATUS: begin
                    st_next.rdata[`STAT_ACTIVE] = st_reg.phase != ST_IDLE;
                    st_next.rdata[`STAT_DONE] = st_reg.done;
                    st_next.rdata[`STAT_ERROR] = st_reg.error;
                    st_next.rdata[`STAT_CFG_DONE] = st_reg.cfg_done;
                    st_next.rdata[`STAT_BUSY] = busy_level;
                    st_next.rdata[`STAT_RATE_SET] = st_reg.rate_set;
                end
                `REG_RDATA: st_next.rdata = st_reg.result;
                default: st_next.rdata = 16'h0000;
            endcase
        end

        // Flags clear by writing ones; a set later in this process wins.
        if (i_write && i_addr == `REG_STATUS) begin
            if (i_wdata[`STAT_DONE]) begin
                st_next.done = 1'b0;
            end
            if (i_wdata[`STAT_ERROR]) begin
                st_next.error = 1'b0;
            end
        end

        // Setup registers are frozen during a frame so the frame stays coherent.
        if (wr_hit) begin
            case (i_addr)
                `REG_CTRL: begin
                    st_next.byte_order = i_wdata[`CTRL_BYTE_ORDER];
                    st_next.wr_mode = i_wdata[`CTRL_WRITE];
                    st_next.wide = i_wdata[`CTRL_WIDE];
                end
                `REG_INSTR: st_next.instr = i_wdata[7:0];
                `REG_WDATA: st_next.wdata = i_wdata;
                `REG_DIRECT: st_next.direct = i_wdata[6:0];
                `REG_RATE: begin
                    st_next.half = rate_in;
                    st_next.rate_set = 1'b1; // R14
                end
                default: begin
                end
            endcase
        end

        case (st_reg.phase)
            ST_IDLE: begin
                st_next.link.cs_n = 1'b1; // R6
                st_next.link.sclk = 1'b0;
                st_next.timer = 12'h000;
                if (i_write && i_addr == `REG_CTRL && i_wdata[`CTRL_GO_REG]) begin
                    if (!st_reg.rate_set) begin
                        st_next.error = 1'b1; // R14
                    end else begin
                        st_next.phase = ST_SHIFT;
                        st_next.is_direct = 1'b0;
                        st_next.is_read = !i_wdata[`CTRL_WRITE];
                        st_next.bits = i_wdata[`CTRL_WIDE] ? 5'd24 : 5'd16; // R10
                        if (!i_wdata[`CTRL_WRITE]) begin
                            st_next.tx = {st_reg.instr, 16'h0000};
                        end else if (i_wdata[`CTRL_WIDE]) begin
                            st_next.tx = {st_reg.instr, st_reg.wdata};
                        end else begin
                            st_next.tx = {st_reg.instr, st_reg.wdata[7:0], 8'h00};
                        end
                        st_next.refosc_frame = i_wdata[`CTRL_WRITE]
                            && !i_wdata[`CTRL_WIDE]
                            && st_reg.instr == `INSTR_REFOSC
                            && st_reg.wdata[7:0] == `DATA_REFOSC; // R12
                        st_next.reset_frame = i_wdata[`CTRL_WRITE]
                            && !i_wdata[`CTRL_WIDE]
                            && st_reg.instr == `INSTR_RESET
                            && st_reg.wdata[7:0] == `DATA_RESET; // R13
                    end
                end else if (i_write && i_addr == `REG_CTRL && i_wdata[`CTRL_GO_DIRECT]) begin
                    // Refused until rate, byte order and oscillator are all set up.
                    if (!st_reg.rate_set || !st_reg.cfg_done || !st_reg.byte_order) begin
                        st_next.error = 1'b1; // R11
                    end else begin
                        st_next.phase = ST_SHIFT;
                        st_next.is_direct = 1'b1;
                        st_next.is_read = 1'b0;
                        st_next.refosc_frame = 1'b0;
                        st_next.reset_frame = 1'b0;
                        st_next.bits = 5'd8;
                        st_next.tx = {1'b1, st_reg.direct, 16'h0000}; // R1 R3
                    end
                end
                if (st_next.phase == ST_SHIFT) begin
                    st_next.link.cs_n = 1'b0; // R6
                    st_next.link.sdi = st_next.tx[23]; // R9
                    st_next.rx = 16'h0000;
                end
            end
            ST_SHIFT: begin
                if (tick) begin
                    if (!st_reg.link.sclk) begin
                        st_next.link.sclk = 1'b1; // R7
                    end else begin
                        st_next.link.sclk = 1'b0; // R7
                        if (st_reg.is_read && st_reg.bits <= (st_reg.wide ? 5'd16 : 5'd8)) begin
                            st_next.rx = {st_reg.rx[14:0], sdo_level}; // R9 R10
                        end
                        st_next.bits = st_reg.bits - 5'd1;
                        st_next.tx = {st_reg.tx[22:0], 1'b0};
                        st_next.link.sdi = st_reg.tx[22];
                        if (st_reg.bits == 5'd1) begin
                            st_next.link.cs_n = 1'b1; // R6
                            st_next.link.sdi = 1'b0;
                            st_next.timer = 12'h000;
                            // The converter starts on its own after the last bit.
                            st_next.phase = st_reg.is_direct ? ST_CONV : ST_GAP; // R2
                            st_next.busy_seen = 1'b0;
                            if (st_reg.refosc_frame) begin
                                st_next.cfg_done = 1'b1; // R12
                            end
                            if (st_reg.reset_frame) begin
                                st_next.cfg_done = 1'b0; // R13
                            end
                        end
                    end
                end
            end
            ST_GAP: begin
                st_next.timer = st_reg.timer + 12'h001;
                if (st_reg.timer == GAP_LAST) begin
                    st_next.phase = ST_IDLE;
                    st_next.done = 1'b1;
                    if (st_reg.is_read) begin
                        st_next.result = st_reg.rx;
                    end
                end
            end
            ST_CONV: begin
                // A lost busy edge would hang the sequencer, hence the time-out.
                st_next.timer = st_reg.timer + 12'h001;
                if (busy_level) begin
                    st_next.busy_seen = 1'b1; // R5
                end
                if (st_reg.busy_seen && !busy_level) begin
                    st_next.phase = ST_IDLE; // R5
                    st_next.done = 1'b1;
                end else if (st_reg.timer == CONV_LAST) begin
                    st_next.phase = ST_IDLE;
                    st_next.error = 1'b1;
                end
            end
            default: begin
                st_next.phase = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_reg <= '0;
            st_reg.link.cs_n <= 1'b1;
            st_reg.half <= HALF_HI;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rdata = st_reg.rdata;
    assign o_sclk = st_reg.link.sclk;
    assign o_cs_n = st_reg.link.cs_n;
    assign o_sdi = st_reg.link.sdi;

    // ======================================================================
    // Checks

    logic [4:0] rise_cnt;
    logic [4:0] frame_len;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rise_cnt <= 5'd0;
            frame_len <= 5'd0;
        end else if (st_reg.phase == ST_IDLE && st_next.phase == ST_SHIFT) begin
            rise_cnt <= 5'd0;
            frame_len <= st_next.bits;
        end else if (!st_reg.link.sclk && st_next.link.sclk) begin
            rise_cnt <= rise_cnt + 5'd1;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking

    default disable iff (i_reset);

    sequence s_frame_start;
        st_reg.phase == ST_IDLE ##1 st_reg.phase == ST_SHIFT;
    endsequence

    sequence s_frame_end;
        st_reg.phase == ST_SHIFT ##1 st_reg.phase != ST_SHIFT;
    endsequence

    a_idle_cs_high: assert property (st_reg.phase == ST_IDLE |-> o_cs_n) // R6
        else $error("select low while idle");

    a_sclk_idle_low: assert property (o_cs_n |-> !o_sclk) // R7
        else $error("serial clock high outside a frame");

    a_sdi_stable_rise: assert property ($rose(o_sclk) |-> $stable(o_sdi)) // R7
        else $error("data changed on the rising clock");

    a_direct_top_bit: assert property ( // R1
        s_frame_start ##0 st_reg.is_direct |-> o_sdi && !o_cs_n)
        else $error("direct byte sent without top bit");

    a_direct_setup: assert property ( // R11
        s_frame_start ##0 st_reg.is_direct |-> st_reg.cfg_done && st_reg.byte_order)
        else $error("direct conversion before setup");

    a_rate_legal: assert property ( // R14
        st_reg.half >= HALF_LO && st_reg.half <= HALF_HI)
        else $error("serial rate out of range");

    a_frame_length: assert property ( // R10
        s_frame_end |-> rise_cnt == frame_len && o_cs_n)
        else $error("wrong number of bits in frame");

    a_refosc_sets: assert property ( // R12
        st_reg.refosc_frame ##0 s_frame_end |-> st_reg.cfg_done)
        else $error("oscillator setup not recorded");

    a_reset_clears: assert property ( // R13
        st_reg.reset_frame ##0 s_frame_end |-> !st_reg.cfg_done)
        else $error("converter reset not recorded");

    a_conv_follows: assert property ( // R2
        s_frame_end ##0 $past(st_reg.is_direct) |-> st_reg.phase == ST_CONV)
        else $error("direct frame not followed by conversion wait");

endmodule : adc_host_ctrl

`default_nettype wire

// ---- tb/adc_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Behavioural converter at the far end of the serial link.
module adc_dev_model #(
    parameter int CONV_NS = 2000
) (
    // Serial link from the host
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    // Serial data and busy back to the host
    output logic o_sdo,
    output logic o_busy
);
    logic [7:0] regs [0:31];
    logic [23:0] shreg;
    logic [7:0] instr;
    logic [15:0] out_sh;
    logic direct;
    logic conv_clock_direction;
    int nbits;
    logic [7:0] cmd_q[$];
    logic [23:0] wr_q[$];

    initial begin
        o_sdo = 1'b0;
        o_busy = 1'b0;
        nbits = 0;
        direct = 1'b0;
        // Held low, so conversions run from the external conversion clock pin.
        conv_clock_direction = 1'b0;
        foreach (regs[i]) regs[i] = 8'h00;
    end

    always @(negedge i_cs_n) begin
        nbits = 0;
        direct = 1'b0;
    end

    // The select line has no keeper here, so the last bit is inverted once released.
    always @(posedge i_cs_n) begin
        o_sdo <= ~o_sdo;
    end

    always @(posedge i_sclk) begin
        if (!i_cs_n) begin
            shreg = {shreg[22:0], i_sdi};
            nbits = nbits + 1;
            if (nbits == 8) begin
                instr = shreg[7:0];
                direct = shreg[7];
                if (direct && !conv_clock_direction) begin
                    cmd_q.push_back(shreg[7:0]);
                    fork
                        begin
                            o_busy = 1'b1;
                            #(CONV_NS);
                            o_busy = 1'b0;
                        end
                    join_none
                end else if (instr[6]) begin
                    out_sh = {regs[instr[4:0]], regs[instr[4:0] + 5'h01]};
                end
            end else if (!direct && !instr[6] && nbits == (instr[5] ? 24 : 16)) begin
                wr_q.push_back(instr[5] ? shreg : {instr, 8'h00, shreg[7:0]});
                if (instr[5]) begin
                    regs[instr[4:0]] = shreg[15:8];
                    regs[instr[4:0] + 5'h01] = shreg[7:0];
                end else begin
                    regs[instr[4:0]] = shreg[7:0];
                end
            end
        end
    end

    always @(negedge i_sclk) begin
        if (!i_cs_n && !direct && instr[6] && nbits >= 8) begin
            o_sdo <= out_sh[15];
            out_sh <= {out_sh[14:0], 1'b0};
        end
    end
endmodule : adc_dev_model

`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adc_host_cfg.svh"

module testbench;
    import adc_host_pkg::*;

    logic i_clk;
    logic i_reset;
    logic [3:0] i_addr;
    logic [15:0] i_wdata;
    logic i_write;
    logic i_read;
    logic [15:0] o_rdata;
    logic o_sclk;
    logic o_cs_n;
    logic o_sdi;
    logic sdo;
    logic busy;
    int miscompares;
    int checks;
    logic [15:0] rv;
    logic [15:0] wd;
    logic [3:0] ch;
    logic [7:0] exp_cmd;

    adc_host_ctrl #(.ADDR_W(4)) DUT (
        .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .o_sclk(o_sclk),
        .o_cs_n(o_cs_n), .o_sdi(o_sdi), .i_sdo(sdo), .i_busy(busy)
    );

    adc_dev_model #(.CONV_NS(2000)) conv (
        .i_sclk(o_sclk), .i_cs_n(o_cs_n), .i_sdi(o_sdi), .o_sdo(sdo), .o_busy(busy)
    );

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // ======================================================================
    // Bus tasks and comparison.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clk);
        i_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clk);
        i_read <= 1'b0;
        #1;
        d = o_rdata;
    endtask : rd

    // Polls until done, then clears it; a run out of polls counts as a mismatch.
    task automatic wait_done();
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < 4000 && !s[`STAT_DONE]; i++) rd(`REG_STATUS, s);
        chk(s & 16'h0007, 16'h0002);
        wr(`REG_STATUS, 16'h0006);
    endtask : wait_done

    task automatic reg_frame(input logic [7:0] ins, input logic [7:0] d, input logic w);
        wr(`REG_INSTR, {8'h00, ins});
        wr(`REG_WDATA, {8'h00, d});
        wr(`REG_CTRL, 16'h0005 | (16'(w) << `CTRL_WRITE));
        wait_done();
    endtask : reg_frame

    task automatic report_and_stop();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #(25ns * 90000);
        miscompares++;
        report_and_stop();
    end

    // ======================================================================
    // Main sequence.
    initial begin
        miscompares = 0;
        checks = 0;
        i_reset = 1'b1;
        i_addr = 4'h0;
        i_wdata = 16'h0000;
        i_write = 1'b0;
        i_read = 1'b0;
        void'($urandom(32'hBCF1));
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(`REG_STATUS, rv);
        chk(rv, 16'h0000);
        chk({14'h0000, o_cs_n, o_sclk}, 16'h0002);
        rd(4'h9, rv);
        chk(rv, 16'h0000);
        // A direct start before any setup must be refused with no frame.
        wr(`REG_CTRL, 16'h0006);
        rd(`REG_STATUS, rv);
        chk(rv & 16'h0007, 16'h0004);
        chk(16'(conv.cmd_q.size()), 16'h0000);
        wr(`REG_STATUS, 16'h0004);
        wr(`REG_RATE, 16'h0005);
        rd(`REG_RATE, rv);
        chk(rv, 16'(`HALF_MIN));
        wr(`REG_RATE, 16'hFFFF);
        rd(`REG_RATE, rv);
        chk(rv, 16'(`HALF_MAX));
        wr(`REG_RATE, 16'($urandom_range(22, 30)));
        rd(`REG_STATUS, rv);
        chk(rv, 16'h0020);
        reg_frame(`INSTR_RESET, `DATA_RESET, 1'b1);
        chk(conv.wr_q.pop_front(), 24'h000000);
        reg_frame(`INSTR_REFOSC, `DATA_REFOSC, 1'b1);
        chk(conv.wr_q.pop_front(), 24'h07003B);
        rd(`REG_STATUS, rv);
        chk(rv & 16'h0008, 16'h0008);
        reg_frame(8'h47, 8'h00, 1'b0);
        rd(`REG_RDATA, rv);
        chk(rv & 16'h00FF, 16'h003B);
        // A 16-bit write, then a 16-bit read of the same register pair.
        wd = 16'($urandom());
        wr(`REG_INSTR, 16'h0025);
        wr(`REG_WDATA, wd);
        wr(`REG_CTRL, 16'h001D);
        wait_done();
        chk(conv.wr_q.pop_front(), {8'h25, wd});
        wr(`REG_INSTR, 16'h0065);
        wr(`REG_CTRL, 16'h0015);
        wait_done();
        rd(`REG_RDATA, rv);
        chk(rv, wd);
        // Every gain code, each with a random channel code.
        for (int g = 0; g < 8; g++) begin
            ch = 4'($urandom_range(0, 15));
            exp_cmd = {1'b1, 3'(g), ch};
            wr(`REG_DIRECT, {9'h000, exp_cmd[6:0]});
            wr(`REG_CTRL, 16'h0006);
            wait_done();
            chk(16'(conv.cmd_q.pop_front()), {8'h00, exp_cmd});
        end
        chk({15'h0000, busy}, 16'h0000);
        chk({15'h0000, o_cs_n}, 16'h0001);
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
